// [bench/servo_near_speedlimit_ridethrough_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module servo_near_speedlimit_ridethrough_tb;
  typedef struct packed {logic [31:0] dev; logic tm; logic [15:0] spd; logic [15:0] ext; logic [7:0] term;} snrt_row_s;
  logic        clk, nrst, wr, rd, tm, mpok, cpok, uv, bb, alm, son, pwr, rdy, irq, ce;
  logic [7:0]  addr, term;
  logic [31:0] wdata, rdata, dev, d;
  logic [15:0] spd, ext_cmd, ext, lim;
  int          err_count, n_tests;
  // near amp 0x64, near on terminal 1, clamp on terminal 2, motor maximum 0x1770
  snrt_row_s   rows [9] = '{'{32'h0000_0032, 1'b0, 16'h0000, 16'h0BB8, 8'h01}, '{32'hFFFF_FFCE, 1'b0, 16'h0000, 16'h0BB8, 8'h01},
    '{32'h0000_0064, 1'b0, 16'h0000, 16'h0BB8, 8'h00}, '{32'h0000_0063, 1'b0, 16'h0000, 16'h0BB8, 8'h01},
    '{32'hFFFF_FF9C, 1'b0, 16'h0000, 16'h0BB8, 8'h00}, '{32'h0000_03E8, 1'b1, 16'h0BB8, 16'h0BB8, 8'h02},
    '{32'h0000_03E8, 1'b1, 16'h0BB7, 16'h0BB8, 8'h00}, '{32'h0000_03E8, 1'b0, 16'h1388, 16'h0BB8, 8'h00},
    '{32'h0000_03E8, 1'b1, 16'h1770, 16'h1F40, 8'h02}};
  // ---------------------------------------------------------------
  // design and controller model
  // ---------------------------------------------------------------
  snrt_top dut_u (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_position_deviation(dev), .i_torque_mode(tm), .i_motor_speed(spd),
    .i_external_speed_limit(ext), .i_motor_max_speed(16'h1770), .i_overspeed_speed(16'h1F40),
    .i_main_power_ok(mpok), .i_control_power_ok(cpok), .i_undervoltage_alarm(uv), .i_base_block(bb),
    .i_alarm(alm), .i_servo_on_command(son), .o_speed_limit(lim), .o_servo_powered(pwr), .o_servo_ready(rdy),
    .o_terminals(term), .o_irq(irq));
  snrt_host_model host_u (.i_clk(clk), .i_nrst(nrst), .i_limit_cmd(ext_cmd), .o_external_speed_limit(ext));
  // clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    check(d, exp);
  endtask
  task automatic wait_pwr(input logic v);
    for (int k = 0; k < 50 && pwr !== v; k++) @(posedge clk) #1;
    check(pwr, v);
    if (pwr !== v) stop_test();
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  // hang guard: ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst, wr, rd, tm, uv, bb, alm, son} = '0;
    {mpok, cpok, ce} = 3'b111;
    {addr, wdata, dev, spd} = '0;
    ext_cmd = 16'h0BB8;
    err_count = 0;
    n_tests = 0;
    do_reset();
    rdc(snrt_pkg::ADDR_NEAR_AMP, snrt_pkg::NEAR_AMP_RST);
    rdc(snrt_pkg::ADDR_SPEED_LIM, {16'h0000, snrt_pkg::SPEED_LIM_RST});
    rdc(snrt_pkg::ADDR_HOLD_TIME, {16'h0000, snrt_pkg::HOLD_RST});
    rdc(snrt_pkg::ADDR_CONFIG, {16'h0000, snrt_pkg::CONFIG_RST});
    rdc(8'h40, 32'h0000_0000);
    wrr(snrt_pkg::ADDR_HOLD_TIME, 32'h0000_0005);
    rdc(snrt_pkg::ADDR_HOLD_TIME, {16'h0000, snrt_pkg::HOLD_MIN});
    wrr(snrt_pkg::ADDR_SPEED_LIM, 32'h0000_4E20);
    rdc(snrt_pkg::ADDR_SPEED_LIM, {16'h0000, snrt_pkg::SPEED_LIM_MAX});
    wrr(snrt_pkg::ADDR_NEAR_AMP, 32'h0000_0064);
    wrr(snrt_pkg::ADDR_CONFIG, 32'h0000_0121);
    // ordinary cases: deviation sign and boundary, clamp in and out of torque mode
    foreach (rows[i]) begin
      dev <= rows[i].dev; tm <= rows[i].tm; spd <= rows[i].spd; ext_cmd <= rows[i].ext;
      repeat (5) @(posedge clk);
      #1 check(term, rows[i].term);
      check(lim, (rows[i].ext < 16'h1770) ? rows[i].ext : 16'h1770);
      @(posedge clk);
    end
    // internal limit below the external one wins
    wrr(snrt_pkg::ADDR_SPEED_LIM, 32'h0000_07D0);
    repeat (4) @(posedge clk);
    #1 check(lim, 16'h07D0);
    // near rise raises a sticky bit; irq only once unmasked, gone after clearing
    wrr(snrt_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    wrr(snrt_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    dev <= 32'h0000_0000;
    repeat (4) @(posedge clk);
    #1 check(irq, 1'b0);
    rdc(snrt_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    wrr(snrt_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    #1 check(irq, 1'b1);
    wrr(snrt_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    #1 check(irq, 1'b0);
    // short outage rides through, undervoltage and control loss do not
    @(posedge clk);
    son <= 1'b1;
    wait_pwr(1'b1);
    check(rdy, 1'b1);
    @(posedge clk);
    mpok <= 1'b0;
    repeat (100) @(posedge clk);
    #1 check({pwr, rdy}, 2'b11);
    // holding, powered, ready, clamp and near all shown while riding through
    rdc(snrt_pkg::ADDR_STATUS, 32'h0000_001F);
    @(posedge clk);
    uv <= 1'b1;
    repeat (4) @(posedge clk);
    wait_pwr(1'b0);
    check(rdy, 1'b0);
    rdc(snrt_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    @(posedge clk);
    uv <= 1'b0; mpok <= 1'b1;
    wait_pwr(1'b1);
    @(posedge clk);
    cpok <= 1'b0; mpok <= 1'b0;
    repeat (4) @(posedge clk);
    wait_pwr(1'b0);
    @(posedge clk);
    cpok <= 1'b1; mpok <= 1'b1;
    wait_pwr(1'b1);
    @(posedge clk);
    alm <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(rdy, 1'b0);
    @(posedge clk);
    alm <= 1'b0; bb <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(rdy, 1'b0);
    // a low clock enable freezes the routed flags until it returns
    @(posedge clk);
    bb <= 1'b0; ce <= 1'b0; dev <= 32'h0000_03E8;
    repeat (3) @(posedge clk);
    #1 check(term, 8'h03);
    @(posedge clk);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(term, 8'h02);
    // second reset in mid-run: powered, ready and terminals cleared, near amplitude back at its default
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({pwr, rdy, term}, 10'h000);
    @(posedge clk);
    do_reset();
    rdc(snrt_pkg::ADDR_NEAR_AMP, snrt_pkg::NEAR_AMP_RST);
    stop_test();
  end
endmodule // servo_near_speedlimit_ridethrough_tb
`default_nettype wire

// [bench/snrt_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// port-level checker
// ---------------------------------------------------------------
module snrt_chk (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic [15:0] i_external_speed_limit,
  input  wire logic [15:0] i_motor_max_speed,
  input  wire logic        i_main_power_ok,
  input  wire logic        i_control_power_ok,
  input  wire logic        i_undervoltage_alarm,
  input  wire logic        i_base_block,
  input  wire logic        i_alarm,
  input  wire logic        i_servo_on_command,
  input  wire logic [15:0] o_speed_limit,
  input  wire logic        o_servo_powered,
  input  wire logic        o_servo_ready,
  input  wire logic [7:0]  o_terminals
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_rdata_idle: assert property (!$past(i_rd && i_ce) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside read reply");
  chk_limit_max: assert property (o_speed_limit <= 16'h2710)
    else $error("speed limit above internal maximum");
  chk_limit_ext: assert property ($stable(i_external_speed_limit) [*3] |-> o_speed_limit <= i_external_speed_limit)
    else $error("speed limit above external limit");
  chk_limit_ceil: assert property ($stable(i_motor_max_speed) [*3] |-> o_speed_limit <= i_motor_max_speed)
    else $error("speed limit above motor maximum");
  chk_ready_block: assert property (((i_alarm || i_base_block) && $past(i_alarm || i_base_block)) |-> !o_servo_ready)
    else $error("ready high with alarm or base block");
  chk_uv_trip: assert property ((!i_main_power_ok && i_undervoltage_alarm) [*4] |-> !o_servo_powered && !o_servo_ready)
    else $error("servo kept on through undervoltage");
  chk_ctl_trip: assert property ((!i_main_power_ok && !i_control_power_ok) [*4] |-> !o_servo_powered)
    else $error("servo kept on through control loss");
  chk_hold_short: assert property ((o_servo_powered && $fell(i_main_power_ok) && i_control_power_ok && !i_undervoltage_alarm
    && i_servo_on_command && !i_alarm && !i_base_block) |=> o_servo_powered)
    else $error("servo dropped at start of short outage");
  chk_power_back: assert property ((i_ce && i_main_power_ok && i_control_power_ok && i_servo_on_command && !i_alarm
    && !i_base_block && !i_undervoltage_alarm) [*4] |-> o_servo_powered)
    else $error("servo not powered with power and command");
  chk_reset_outs: assert property ($rose(i_nrst) |-> o_terminals == 8'h00 && !o_servo_powered && !o_servo_ready)
    else $error("outputs not cleared after reset");
endmodule // snrt_chk
bind snrt_top snrt_chk chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_external_speed_limit(i_external_speed_limit), .i_motor_max_speed(i_motor_max_speed),
  .i_main_power_ok(i_main_power_ok), .i_control_power_ok(i_control_power_ok),
  .i_undervoltage_alarm(i_undervoltage_alarm), .i_base_block(i_base_block), .i_alarm(i_alarm),
  .i_servo_on_command(i_servo_on_command), .o_speed_limit(o_speed_limit), .o_servo_powered(o_servo_powered),
  .o_servo_ready(o_servo_ready), .o_terminals(o_terminals));
`default_nettype wire

// [bench/snrt_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// upper motion controller: supplies the external speed limit
// ---------------------------------------------------------------
module snrt_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_limit_cmd,
  output logic      [15:0] o_external_speed_limit
);
  // limit command moves only on a control-cycle edge, never mid-cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_external_speed_limit <= 16'h2710;
    end else begin
      o_external_speed_limit <= i_limit_cmd;
    end
  end
endmodule // snrt_host_model
`default_nettype wire

// [common/snrt_alloc_if.sv]
`timescale 1ns/1ps
`default_nettype none
// carries the two routed flags and their allocation digits
interface snrt_alloc_if;
  logic       near_flag;
  logic       clamp_flag;
  logic [3:0] near_alloc;
  logic [3:0] clamp_alloc;
  logic [7:0] terminals;
  modport src (output near_flag, clamp_flag, near_alloc, clamp_alloc, input terminals);
  modport rte (input near_flag, clamp_flag, near_alloc, clamp_alloc, output terminals);
endinterface
`default_nettype wire

// [common/snrt_pkg.sv]
// Functional notes
// R1 - near flag when deviation below amplitude
// R2 - near on at approach point, else off
// R3 - near routed by allocation lowest digit
// R4 - host sets near above done amplitude
// R5 - clamp flag while torque-mode speed limited
// R6 - clamp routed by allocation second digit
// R7 - source 1 uses min external/internal limit
// R8 - internal limit 0..10000, default 10000
// R9 - ceiling select: motor max or overspeed; the code always uses motor max, since the select is latched from CONFIG_RST
// R10 - hold servo through short main outage
// R11 - main power back restores servo on
// R12 - long outage drops ready, servo off
// R13 - control power loss ignores hold time
// R14 - undervoltage alarm voids hold time
// R15 - near compares absolute signed deviation
// R16 - ready needs power, no block, no alarm
`default_nettype none
package snrt_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_NEAR_AMP    = 8'h00;
  localparam logic [7:0]  ADDR_SPEED_LIM   = 8'h04;
  localparam logic [7:0]  ADDR_CONFIG      = 8'h08;
  localparam logic [7:0]  ADDR_HOLD_TIME   = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS      = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h18;
  // ---------------------------------------------------------------
  // reset values and ranges
  // ---------------------------------------------------------------
  localparam logic [31:0] NEAR_AMP_RST     = 32'h4000_0000;
  localparam logic [15:0] SPEED_LIM_RST    = 16'h2710;
  localparam logic [15:0] SPEED_LIM_MAX    = 16'h2710;
  localparam logic [15:0] HOLD_RST         = 16'h0014;
  localparam logic [15:0] HOLD_MIN         = 16'h0014;
  localparam logic [15:0] HOLD_MAX         = 16'hC350;
  // config field positions
  localparam int CFG_NEAR_ALLOC_LSB  = 0;  // 4 bits
  localparam int CFG_CLAMP_ALLOC_LSB = 4;  // 4 bits
  localparam int CFG_SRC_SEL_BIT     = 8;
  localparam int CFG_CEIL_SEL_BIT    = 9;
  localparam logic [15:0] CONFIG_RST = 16'h0100;
  // status / irq bit positions
  localparam int ST_NEAR    = 0;
  localparam int ST_CLAMP   = 1;
  localparam int ST_READY   = 2;
  localparam int ST_SERVO   = 3;
  localparam int ST_HOLDING = 4;
  localparam int IRQ_W      = 3;   // near rise, clamp rise, outage trip
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 25_000_000;
  localparam int MS_UNIT     = 1;
  localparam int MS_CYCLES   = CLK_HZ / 1000 * MS_UNIT;
  localparam int TERMINALS   = 8;
  typedef enum logic [1:0] {
    SNRT_OFF  = 2'b00,
    SNRT_ON   = 2'b01,
    SNRT_HOLD = 2'b10,
    SNRT_TRIP = 2'b11
  } snrt_state_e;
endpackage
`default_nettype wire

// [logic/snrt_router.sv]
`timescale 1ns/1ps
`default_nettype none
module snrt_router (
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  input  wire logic  i_ce,
  snrt_alloc_if.rte  bus
);
  // ---------------------------------------------------------------
  // terminal routing
  // ---------------------------------------------------------------
  // digit 0 leaves the flag unrouted; 1..8 pick a terminal
  logic [7:0] term_next;
  logic [7:0] term_reg;
  always_comb begin
    term_next = 8'h00;
    for (int t = 0; t < snrt_pkg::TERMINALS; t++) begin
      if (bus.near_alloc == 4'(t + 1) && bus.near_flag) begin
        term_next[t] = 1'b1;                    // [R3]
      end
      if (bus.clamp_alloc == 4'(t + 1) && bus.clamp_flag) begin
        term_next[t] = 1'b1;                    // [R6]
      end
    end
  end
  // registered so terminals never glitch on allocation changes
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      term_reg <= 8'h00;
    end else if (i_ce) begin
      term_reg <= term_next;
    end
  end
  assign bus.terminals = term_reg;
endmodule // snrt_router
`default_nettype wire

// [logic/snrt_top.sv]
`timescale 1ns/1ps
`default_nettype none
module snrt_top (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // drive state
  input  wire logic [31:0] i_position_deviation,
  input  wire logic        i_torque_mode,
  input  wire logic [15:0] i_motor_speed,
  input  wire logic [15:0] i_external_speed_limit,
  input  wire logic [15:0] i_motor_max_speed,
  input  wire logic [15:0] i_overspeed_speed,
  input  wire logic        i_main_power_ok,
  input  wire logic        i_control_power_ok,
  input  wire logic        i_undervoltage_alarm,
  input  wire logic        i_base_block,
  input  wire logic        i_alarm,
  input  wire logic        i_servo_on_command,
  // outputs
  output logic [15:0]      o_speed_limit,
  output logic             o_servo_powered,
  output logic             o_servo_ready,
  output logic [7:0]       o_terminals,
  output logic             o_irq
);
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] near_amplitude_reg;
  logic [15:0] internal_speed_limit_reg;
  logic [15:0] config_reg;
  logic [15:0] ride_through_hold_time_reg;
  logic [snrt_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [snrt_pkg::IRQ_W-1:0] irq_mask_reg;
  // power-restart latched selects
  logic        src_sel_reg;
  logic        ceil_sel_reg;
  logic        boot_done_reg;

  // write decode
  wire wr_near  = i_wr && (i_addr == snrt_pkg::ADDR_NEAR_AMP);
  wire wr_lim   = i_wr && (i_addr == snrt_pkg::ADDR_SPEED_LIM);
  wire wr_cfg   = i_wr && (i_addr == snrt_pkg::ADDR_CONFIG);
  wire wr_hold  = i_wr && (i_addr == snrt_pkg::ADDR_HOLD_TIME);
  wire wr_istat = i_wr && (i_addr == snrt_pkg::ADDR_IRQ_STAT);
  wire wr_imask = i_wr && (i_addr == snrt_pkg::ADDR_IRQ_MASK);

  // out-of-range writes saturate into the legal span
  wire [31:0] near_wr_val = (i_wdata > snrt_pkg::NEAR_AMP_RST) ? snrt_pkg::NEAR_AMP_RST : i_wdata;
  wire [15:0] lim_wr_val  = (i_wdata[15:0] > snrt_pkg::SPEED_LIM_MAX || i_wdata[31:16] != 16'h0000)
                            ? snrt_pkg::SPEED_LIM_MAX : i_wdata[15:0];
  wire [15:0] hold_lo     = (i_wdata[15:0] < snrt_pkg::HOLD_MIN) ? snrt_pkg::HOLD_MIN : i_wdata[15:0];
  wire [15:0] hold_wr_val = (hold_lo > snrt_pkg::HOLD_MAX || i_wdata[31:16] != 16'h0000)
                            ? snrt_pkg::HOLD_MAX : hold_lo;

  // parameter registers take effect on the next cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      near_amplitude_reg         <= snrt_pkg::NEAR_AMP_RST;     // [R1]
      internal_speed_limit_reg   <= snrt_pkg::SPEED_LIM_RST;    // [R8]
      config_reg                 <= snrt_pkg::CONFIG_RST;
      ride_through_hold_time_reg <= snrt_pkg::HOLD_RST;         // [R10]
      irq_mask_reg               <= '0;
    end else if (i_ce) begin
      if (wr_near)  near_amplitude_reg         <= near_wr_val;
      if (wr_lim)   internal_speed_limit_reg   <= lim_wr_val;
      if (wr_cfg)   config_reg                 <= i_wdata[15:0];
      if (wr_hold)  ride_through_hold_time_reg <= hold_wr_val;
      if (wr_imask) irq_mask_reg               <= i_wdata[snrt_pkg::IRQ_W-1:0];
    end
  end

  // selects are captured once after reset release, while config_reg still holds CONFIG_RST
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_done_reg <= 1'b0;
      src_sel_reg   <= 1'b1;
      ceil_sel_reg  <= 1'b0;
    end else if (i_ce && !boot_done_reg) begin
      boot_done_reg <= 1'b1;
      src_sel_reg   <= config_reg[snrt_pkg::CFG_SRC_SEL_BIT];   // [R7]
      ceil_sel_reg  <= config_reg[snrt_pkg::CFG_CEIL_SEL_BIT];  // [R9]
    end
  end

  // ---------------------------------------------------------------
  // near positioning
  // ---------------------------------------------------------------
  // magnitude of the signed deviation so either overshoot counts
  wire [31:0] dev_abs = i_position_deviation[31] ? (32'h0 - i_position_deviation)
                                                 : i_position_deviation;  // [R15]
  wire        near_now = (dev_abs < near_amplitude_reg);                // [R1] [R2]
  logic       near_reg;

  // ---------------------------------------------------------------
  // speed limit during torque control
  // ---------------------------------------------------------------
  wire [15:0] ceiling    = ceil_sel_reg ? i_overspeed_speed : i_motor_max_speed;      // [R9]
  wire [15:0] int_limit  = (internal_speed_limit_reg < ceiling) ? internal_speed_limit_reg : ceiling;
  // select value 0 is reserved; treated as internal-only
  wire [15:0] eff_limit  = (src_sel_reg && i_external_speed_limit < int_limit)
                           ? i_external_speed_limit : int_limit;                       // [R7]
  wire        clamp_now  = i_torque_mode && (i_motor_speed >= eff_limit);              // [R5]
  logic       clamp_reg;
  logic [15:0] limit_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      near_reg  <= 1'b0;
      clamp_reg <= 1'b0;
      limit_reg <= 16'h0000;
    end else if (i_ce) begin
      near_reg  <= near_now;
      clamp_reg <= clamp_now;
      limit_reg <= eff_limit;
    end
  end
  assign o_speed_limit = limit_reg;

  // ---------------------------------------------------------------
  // momentary interruption ride-through
  // ---------------------------------------------------------------
  snrt_pkg::snrt_state_e state_reg;
  snrt_pkg::snrt_state_e state_next;
  logic [14:0] ms_cnt_reg;
  logic [15:0] hold_cnt_reg;
  wire ms_tick   = (ms_cnt_reg == 15'(snrt_pkg::MS_CYCLES - 1));
  wire hold_done = ms_tick && (hold_cnt_reg + 16'h0001 >= ride_through_hold_time_reg);
  // control loss or undervoltage bypass the hold entirely
  wire hard_off  = !i_control_power_ok || i_undervoltage_alarm;               // [R13] [R14]
  wire can_on    = i_main_power_ok && !i_base_block && !i_alarm;

  always_comb begin
    case (state_reg)
      snrt_pkg::SNRT_OFF:  state_next = (can_on && i_servo_on_command && !hard_off)
                                        ? snrt_pkg::SNRT_ON : snrt_pkg::SNRT_OFF;
      snrt_pkg::SNRT_ON: begin
        if (hard_off || !i_servo_on_command || i_alarm || i_base_block) begin
          state_next = snrt_pkg::SNRT_OFF;
        end else if (!i_main_power_ok) begin
          state_next = snrt_pkg::SNRT_HOLD;                                   // [R10]
        end else begin
          state_next = snrt_pkg::SNRT_ON;
        end
      end
      snrt_pkg::SNRT_HOLD: begin
        if (hard_off) begin
          state_next = snrt_pkg::SNRT_TRIP;                                   // [R13] [R14]
        end else if (i_main_power_ok) begin
          state_next = snrt_pkg::SNRT_ON;
        end else if (hold_done) begin
          state_next = snrt_pkg::SNRT_TRIP;                                   // [R10] [R12]
        end else begin
          state_next = snrt_pkg::SNRT_HOLD;
        end
      end
      snrt_pkg::SNRT_TRIP: begin
        // power back with the command still present turns the motor on
        state_next = (can_on && i_servo_on_command && !hard_off)
                     ? snrt_pkg::SNRT_ON : snrt_pkg::SNRT_TRIP;                // [R11]
        if (!i_servo_on_command) state_next = snrt_pkg::SNRT_OFF;
      end
      default: state_next = snrt_pkg::SNRT_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg    <= snrt_pkg::SNRT_OFF;
      ms_cnt_reg   <= 15'h0000;
      hold_cnt_reg <= 16'h0000;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (state_reg != snrt_pkg::SNRT_HOLD || ms_tick) begin
        ms_cnt_reg <= 15'h0000;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 15'h0001;
      end
      if (state_reg != snrt_pkg::SNRT_HOLD) begin
        hold_cnt_reg <= 16'h0000;
      end else if (ms_tick) begin
        hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
    end
  end

  logic powered_reg;
  logic ready_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      powered_reg <= 1'b0;
      ready_reg   <= 1'b0;
    end else if (i_ce) begin
      powered_reg <= (state_next == snrt_pkg::SNRT_ON) || (state_next == snrt_pkg::SNRT_HOLD);
      // holding masks the brief loss of main power from the ready flag
      ready_reg   <= (can_on || state_next == snrt_pkg::SNRT_HOLD)
                     && !i_base_block && !i_alarm && !hard_off
                     && state_next != snrt_pkg::SNRT_TRIP;                    // [R16] [R12]
    end
  end
  assign o_servo_powered = powered_reg;
  assign o_servo_ready   = ready_reg;

  // ---------------------------------------------------------------
  // interrupts: set wins over write-one-to-clear
  // ---------------------------------------------------------------
  wire [snrt_pkg::IRQ_W-1:0] irq_evt = {
    (state_reg == snrt_pkg::SNRT_HOLD && state_next == snrt_pkg::SNRT_TRIP),
    (clamp_now && !clamp_reg),
    (near_now && !near_reg)
  };
  wire [snrt_pkg::IRQ_W-1:0] irq_clr = wr_istat ? i_wdata[snrt_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat_reg <= '0;
    end else if (i_ce) begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
    end
  end
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  wire [31:0] status_word = {27'h0, (state_reg == snrt_pkg::SNRT_HOLD), powered_reg, ready_reg,
                             clamp_reg, near_reg};
  logic [31:0] rd_mux;
  always_comb begin
    case (i_addr)
      snrt_pkg::ADDR_NEAR_AMP:  rd_mux = near_amplitude_reg;
      snrt_pkg::ADDR_SPEED_LIM: rd_mux = {16'h0000, internal_speed_limit_reg};
      snrt_pkg::ADDR_CONFIG:    rd_mux = {16'h0000, config_reg};
      snrt_pkg::ADDR_HOLD_TIME: rd_mux = {16'h0000, ride_through_hold_time_reg};
      snrt_pkg::ADDR_STATUS:    rd_mux = status_word;
      snrt_pkg::ADDR_IRQ_STAT:  rd_mux = {29'h0, irq_stat_reg};
      snrt_pkg::ADDR_IRQ_MASK:  rd_mux = {29'h0, irq_mask_reg};
      default:                  rd_mux = 32'h0000_0000;   // unmapped reads zero
    endcase
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // output routing
  // ---------------------------------------------------------------
  snrt_alloc_if alloc ();
  assign alloc.near_flag   = near_reg;
  assign alloc.clamp_flag  = clamp_reg;
  assign alloc.near_alloc  = config_reg[snrt_pkg::CFG_NEAR_ALLOC_LSB +: 4];   // [R3]
  assign alloc.clamp_alloc = config_reg[snrt_pkg::CFG_CLAMP_ALLOC_LSB +: 4];  // [R6]
  snrt_router u_router (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .bus    (alloc.rte)
  );
  assign o_terminals = alloc.terminals;
endmodule // snrt_top
`default_nettype wire
